// File: core/drt_timer.sv
// dual 16-bit reload timer with Avalon-MM register slave
// ****************************************************************
// Operation
// - two independent 16-bit reload timers, each with output and interrupt
// - prescaler divides count clock by 1 to 128
// - counter mode restarts at 0001H after every reload
// - counter mode: polarity 0 counts rising, 1 counts falling edges
// - counter mode: count edge sets initial output level
// - counter mode, enabled: output toggles at each reload
// - count minus start equals input edges of the selected polarity seen, until the first reload
// - comparator counter: counts comparator edges, prescaler bypassed
// - one-shot, continuous, compare: disabled drives polarity, enabled toggles
// - pwm, polarity 0: low disabled, high on match, low on reload
// - pwm, polarity 1: high disabled, low on match, high on reload
// - capture: polarity 0 captures on rising, 1 on falling edge
// - capture modes store count in pwm capture bytes
// - pwm value compared with count; match changes output in pwm mode only
// ****************************************************************
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module drt_timer
    import drt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [1:0]  timer_in,
    input  wire logic [1:0]  comparator_out,
    output logic      [1:0]  timer_out,
    output logic             irq
);
    // ****************************************************************
    // bus handshake: one wait cycle, then the access completes
    // ****************************************************************
    logic            ack;
    logic            next_ack;
    logic [31:0]     next_readdata;
    logic [1:0]      status;
    logic [1:0]      next_status;
    logic [1:0]      mask;
    logic [1:0]      next_mask;
    drt_timer_t      tmr [2];
    drt_timer_t      next_tmr [2];
    logic [1:0]      in_s1, in_s2, in_q;
    logic [1:0]      cmp_s1, cmp_s2, cmp_q;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign timer_out = {tmr[1].out_level, tmr[0].out_level};
    assign irq = |(status & mask);

    function automatic logic sel_edge(input logic prev, input logic cur,
                                      input logic pol);
        sel_edge = pol ? (prev & ~cur) : (~prev & cur);
    endfunction

    function automatic logic [7:0] pre_limit(input logic [2:0] sel);
        pre_limit = 8'h01 << sel;
    endfunction

    // ****************************************************************
    // next-state logic for bus, status and both timers
    // ****************************************************************
    always_comb begin
        logic        bus_done;
        logic [7:0]  off;
        logic        idx;
        logic        tick;
        logic        in_edge;
        logic        reload_hit;
        logic        pwm_hit;
        drt_ctl_t    c;
        bus_done      = (avs_read | avs_write) & ack;
        off           = 8'h00;
        idx           = 1'b0;
        tick          = 1'b0;
        in_edge       = 1'b0;
        reload_hit    = 1'b0;
        pwm_hit       = 1'b0;
        c             = '0;
        next_ack      = (avs_read | avs_write) & ~ack;
        next_readdata = avs_readdata;
        next_status   = status;
        next_mask     = mask;
        next_tmr      = tmr;
        for (int i = 0; i < 2; i++) begin
            // per-timer flags must not leak from timer 0 into timer 1
            tick       = 1'b0;
            reload_hit = 1'b0;
            pwm_hit    = 1'b0;
            c = tmr[i].timer_control_one;
            next_tmr[i].irq_event = 1'b0;
            in_edge = sel_edge(in_q[i], in_s2[i], c.io_polarity_select);
            if (c.enable) begin
                if (c.mode == DRT_COUNTER) begin
                    tick = in_edge;
                end else if (c.mode == DRT_CMP_COUNT) begin
                    tick = sel_edge(cmp_q[i], cmp_s2[i],
                                    c.io_polarity_select);
                end else begin
                    next_tmr[i].prediv = tmr[i].prediv + 7'h01;
                    tick = ({1'b0, tmr[i].prediv} + 8'h01
                            >= pre_limit(c.prescale));
                    if (tick)
                        next_tmr[i].prediv = '0;
                end
                if ((c.mode == DRT_CAPTURE || c.mode == DRT_CAP_CMP)
                    && in_edge) begin
                    next_tmr[i].match_value_high = tmr[i].count[15:8];
                    next_tmr[i].match_value_low  = tmr[i].count[7:0];
                end
                pwm_hit = tmr[i].count == {tmr[i].match_value_high,
                                           tmr[i].match_value_low};
                if (tick) begin
                    reload_hit = tmr[i].count == tmr[i].reload;
                    if (reload_hit) begin
                        next_tmr[i].count = DRT_COUNT_RESTART;
                        next_tmr[i].irq_event = 1'b1;
                        if (c.mode == DRT_ONE_SHOT)
                            next_tmr[i].timer_control_one.enable = 1'b0;
                        if (c.mode == DRT_PWM_SINGLE)
                            next_tmr[i].out_level = c.io_polarity_select;
                        else
                            next_tmr[i].out_level = ~tmr[i].out_level;
                    end else begin
                        next_tmr[i].count = tmr[i].count + 16'h0001;
                    end
                end
                if (c.mode == DRT_PWM_SINGLE && pwm_hit && !reload_hit)
                    next_tmr[i].out_level = ~c.io_polarity_select;
            end else begin
                next_tmr[i].prediv = '0;
                // idle level follows polarity in every mode
                next_tmr[i].out_level = c.io_polarity_select;
            end
            if (next_tmr[i].irq_event)
                next_status[i] = 1'b1;
        end
        // read data are registered in the wait cycle so that they stand
        // when waitrequest drops; writes land at the completing edge
        if (avs_read | avs_write) begin
            off = avs_address;
            idx = off >= DRT_TIMER_SPAN && off < DRT_OFF_STATUS;
            if (idx)
                off = off - DRT_TIMER_SPAN;
            next_readdata = DRT_UNMAPPED_READ;
            if (avs_address == DRT_OFF_STATUS) begin
                next_readdata = {30'h0, status};
                // only bits already shown are cleared; a new event wins
                if (avs_read && bus_done)
                    next_status = (status & ~avs_readdata[1:0])
                                  | {next_tmr[1].irq_event,
                                     next_tmr[0].irq_event};
            end else if (avs_address == DRT_OFF_MASK) begin
                next_readdata = {30'h0, mask};
                if (avs_write && bus_done)
                    next_mask = avs_writedata[1:0];
            end else if (avs_address < DRT_OFF_STATUS) begin
                case (off)
                    DRT_OFF_COUNT: begin
                        next_readdata = {16'h0, tmr[idx].count};
                        if (avs_write && bus_done)
                            next_tmr[idx].count = avs_writedata[15:0];
                    end
                    DRT_OFF_RELOAD: begin
                        next_readdata = {16'h0, tmr[idx].reload};
                        if (avs_write && bus_done)
                            next_tmr[idx].reload = avs_writedata[15:0];
                    end
                    DRT_OFF_PWM: begin
                        next_readdata = {16'h0, tmr[idx].match_value_high,
                                         tmr[idx].match_value_low};
                        if (avs_write && bus_done) begin
                            next_tmr[idx].match_value_high = avs_writedata[15:8];
                            next_tmr[idx].match_value_low  = avs_writedata[7:0];
                        end
                    end
                    DRT_OFF_CTL: begin
                        next_readdata = {24'h0, tmr[idx].timer_control_one};
                        if (avs_write && bus_done)
                            next_tmr[idx].timer_control_one = avs_writedata[7:0];
                    end
                    default: begin
                        next_readdata = DRT_UNMAPPED_READ;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack          <= 1'b0;
            avs_readdata <= '0;
            status       <= '0;
            mask         <= '0;
            in_s1 <= '0; in_s2 <= '0; in_q <= '0;
            cmp_s1 <= '0; cmp_s2 <= '0; cmp_q <= '0;
            for (int i = 0; i < 2; i++) begin
                tmr[i]        <= '0;
                tmr[i].count  <= DRT_RESET_COUNT;
                tmr[i].reload <= DRT_RESET_RELOAD;
            end
        end else begin
            ack          <= next_ack;
            avs_readdata <= next_readdata;
            status       <= next_status;
            mask         <= next_mask;
            // first stage feeds only the second stage
            in_s1  <= timer_in;
            in_s2  <= in_s1;
            in_q   <= in_s2;
            cmp_s1 <= comparator_out;
            cmp_s2 <= cmp_s1;
            cmp_q  <= cmp_s2;
            tmr    <= next_tmr;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_oneshot_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
        tmr[1].irq_event && $past(tmr[1].timer_control_one.mode) == DRT_ONE_SHOT
        && !$past(avs_write) |-> !tmr[1].timer_control_one.enable)
        else $error("one-shot timer still enabled after reload");
    a_restart_value: assert property (@(posedge clk_sys) disable iff (!nrst)
        tmr[0].irq_event && !$past(avs_write) |-> tmr[0].count == 16'h0001)
        else $error("counter did not restart at 0001");
    a_idle_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        !tmr[1].timer_control_one.enable ##1 !tmr[1].timer_control_one.enable
        |-> timer_out[1] == $past(tmr[1].timer_control_one.io_polarity_select))
        else $error("idle output not at polarity");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        irq == |(status & mask))
        else $error("interrupt output mismatch");
    a_event_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
        tmr[0].irq_event |-> status[0])
        else $error("reload event not recorded");
    a_bus_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered in one wait cycle");
    c_reload: cover property (@(posedge clk_sys) tmr[0].irq_event);
    c_irq: cover property (@(posedge clk_sys) $rose(irq));
    c_pwm: cover property (@(posedge clk_sys)
        tmr[1].timer_control_one.mode == DRT_PWM_SINGLE && $rose(timer_out[1]));
endmodule
`default_nettype wire

// File: core/drt_pkg.sv
// package: register map, field layout and types of the dual reload timer
package drt_pkg;
    // register word offsets (byte addresses), one block of 0x20 per timer
    localparam logic [7:0] DRT_OFF_COUNT   = 8'h00;
    localparam logic [7:0] DRT_OFF_RELOAD  = 8'h04;
    localparam logic [7:0] DRT_OFF_PWM     = 8'h08;
    localparam logic [7:0] DRT_OFF_CTL     = 8'h0C;
    localparam logic [7:0] DRT_OFF_STATUS  = 8'h40;
    localparam logic [7:0] DRT_OFF_MASK    = 8'h44;
    localparam logic [7:0] DRT_TIMER_SPAN  = 8'h20;
    // control word fields
    localparam int DRT_CTL_EN_BIT   = 7;
    localparam int DRT_CTL_POL_BIT  = 6;
    localparam int DRT_CTL_PRE_LSB  = 3;
    localparam int DRT_CTL_MODE_LSB = 0;
    localparam logic [15:0] DRT_COUNT_RESTART = 16'h0001;
    localparam logic [15:0] DRT_RESET_COUNT   = 16'h0001;
    localparam logic [15:0] DRT_RESET_RELOAD  = 16'hFFFF;
    localparam logic [31:0] DRT_UNMAPPED_READ = 32'h0000_0000;

    typedef enum logic [2:0] {
        DRT_ONE_SHOT   = 3'h0,
        DRT_CONTINUOUS = 3'h1,
        DRT_COUNTER    = 3'h2,
        DRT_PWM_SINGLE = 3'h3,
        DRT_CAPTURE    = 3'h4,
        DRT_COMPARE    = 3'h5,
        DRT_CMP_COUNT  = 3'h6,
        DRT_CAP_CMP    = 3'h7
    } drt_mode_t;

    typedef struct packed {
        logic        enable;
        logic        io_polarity_select;
        logic [2:0]  prescale;
        drt_mode_t   mode;
    } drt_ctl_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0]  match_value_high;
        logic [7:0]  match_value_low;
        drt_ctl_t    timer_control_one;
        logic [6:0]  prediv;
        logic        out_level;
        logic        irq_event;
    } drt_timer_t;
endpackage

// File: dv/drt_pins_model.sv
// pin model: timer input sources and comparator outputs
`timescale 1ns/1ns
`default_nettype none
module drt_pins_model (
    input  wire logic       clk_sys,
    output logic      [1:0] timer_in,
    output logic      [1:0] comparator_out
);
    logic [3:0] lines = 4'h0;
    assign timer_in       = lines[1:0];
    assign comparator_out = lines[3:2];
    // sel 0..1 timer inputs, 2..3 comparators; idle low between pulses
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            repeat (2) begin
                @(posedge clk_sys);
                lines[sel] <= ~lines[sel];
                repeat (3) @(posedge clk_sys);
            end
        end
    endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the dual reload timer
`timescale 1ns/1ns
`default_nettype none
module tb;
    import drt_pkg::*;
    logic        clk_sys;
    logic        nrst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  timer_in;
    logic [1:0]  comparator_out;
    logic [1:0]  timer_out;
    logic        irq;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [31:0] rd;
    logic [31:0] cap;
    drt_timer dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer_in(timer_in), .comparator_out(comparator_out),
        .timer_out(timer_out), .irq(irq));
    drt_pins_model pins_u (.clk_sys(clk_sys), .timer_in(timer_in),
        .comparator_out(comparator_out));
    // ****************************************************************
    // bus and check helpers
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do
            @(posedge clk_sys);
        while (avs_waitrequest);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rdc(input string w, input logic [7:0] a,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        chk(w, e, rd);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pin(input string w, input int i, input logic e);
        waitc(2);
        chk(w, {31'h0, e}, {31'h0, timer_out[i]});
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        chk("out at reset", 32'h0, {30'h0, timer_out});
        rdc("count", 8'h00, 32'h1);
        rdc("reload", 8'h24, 32'hFFFF);
        rdc("ctl", 8'h2C, 32'h0);
        rdc("unmapped", 8'h60, 32'h0);
    endtask
    task automatic t_count(input logic [7:0] c, input int s, input logic m);
        wr(8'h0C, {24'h0, c});
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h4);
        wr(8'h44, {31'h0, m});
        bus(1'b0, 8'h40, 32'h0, rd);
        if (c[2:0] == 3'h2) pin("start level", 0, c[6]);
        wr(8'h0C, {24'h0, c | 8'h80});
        pins_u.pulse(s, 5);
        waitc(4);
        rdc("edge count", 8'h00, 32'h2);
        pin("reload toggle", 0, !c[6]);
        chk("irq", {31'h0, m}, {31'h0, irq});
        rdc("status", 8'h40, 32'h1);
        rdc("status clear", 8'h40, 32'h0);
        waitc(2);
        chk("irq clear", 32'h0, {31'h0, irq});
    endtask
    task automatic t_pwm();
        wr(8'h2C, 32'h03);
        pin("pwm idle", 1, 1'b0);
        wr(8'h20, 32'h1);
        wr(8'h24, 32'h20);
        wr(8'h28, 32'h10);
        wr(8'h2C, 32'h83);
        waitc(9);
        pin("before match", 1, 1'b0);
        waitc(11);
        pin("after match", 1, 1'b1);
        waitc(10);
        pin("after reload", 1, 1'b0);
        wr(8'h2C, 32'h43);
        pin("pwm idle high", 1, 1'b1);
        bus(1'b0, 8'h40, 32'h0, rd);
    endtask
    task automatic t_cap();
        wr(8'h0C, 32'h3C);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'hFFFF);
        wr(8'h0C, 32'hBC);
        waitc(20);
        pins_u.pulse(0, 1);
        waitc(4);
        wr(8'h0C, 32'h3C);
        bus(1'b0, 8'h00, 32'h0, cap);
        rdc("capture", 8'h08, cap);
        chk("prescaled", 32'h1, {31'h0, cap < 32'h3});
    endtask
    task automatic t_oneshot();
        wr(8'h2C, 32'h40);
        pin("oneshot idle", 1, 1'b1);
        wr(8'h20, 32'h1);
        wr(8'h24, 32'h3);
        bus(1'b0, 8'h40, 32'h0, rd);
        wr(8'h2C, 32'hC0);
        waitc(20);
        rdc("oneshot stop", 8'h2C, 32'h40);
        rdc("oneshot status", 8'h40, 32'h2);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        nrst          = 1'b0;
        avs_address   = 8'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset();
        t_count(8'h02, 0, 1'b1);
        t_count(8'h42, 0, 1'b0);
        t_count(8'h3E, 2, 1'b1);
        t_pwm();
        t_cap();
        t_oneshot();
        conclude();
    end
    // run takes about 400 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
endmodule
`default_nettype wire
